// *** iop_pkg.sv ***
/*
  shared constants for the i/o bus peripheral: select codes, pin vector
  layout, timing counts, and the interval timer that raises the flag.
  assumes a single 20 MHz clock and an asynchronous active-high reset.
*/
`default_nettype none

package iop_pkg;
  // clock rate
  localparam int CLK_MHZ = 20;                          // system clock in MHz
  // widths
  localparam int DATA_W  = 18;                          // bus data lines
  localparam int SEL_W   = 8;                           // device + subdevice select
  localparam int CTL_W   = 10;                          // control pins
  localparam int PIN_W   = CTL_W + SEL_W + 2 * DATA_W;  // every sampled pin
  // control pin positions in the pin vector
  localparam int C_SYNC  = 0;                           // bus sync pulse
  localparam int C_PCLR  = 1;                           // bus power clear
  localparam int C_TEST  = 2;                           // flag test pulse
  localparam int C_D2C   = 3;                           // device to cpu pulse
  localparam int C_C2D   = 4;                           // cpu to device pulse
  localparam int C_STAT  = 5;                           // status readback
  localparam int C_GRANT = 6;                           // level 0 grant
  localparam int C_CHAIN = 7;                           // chain enable in
  localparam int C_FIT   = 8;                           // priority logic fitted
  localparam int C_CLKEN = 9;                           // interval clock enable
  // field starts in the pin vector
  localparam int P_SEL   = CTL_W;                       // select lines
  localparam int P_DIN   = CTL_W + SEL_W;               // bus data in
  localparam int P_SW    = CTL_W + SEL_W + DATA_W;      // contact switches
  // select codes
  localparam logic [5:0] DEV_CODE = 6'h2A;              // device code
  localparam logic [1:0] SUB_XFER = 2'h0;               // skip, read, write
  localparam logic [1:0] SUB_CLR  = 2'h1;               // clear flag
  // trap address 44 octal, and the status line
  localparam logic [5:0] TRAP_ADDR  = 6'h24;            // level 0 entry point
  localparam int         STATUS_BIT = 5;                // preassigned status line
  // interval clock
  localparam int INTERVAL_US = 1000;                    // flag interval in us
  localparam int TICK_CYCLES = INTERVAL_US * CLK_MHZ;   // cycles per tick
  localparam int TICK_W      = 15;                      // tick counter width
  // internal power-up clear
  localparam int PWRUP_US    = 1;                       // hold-off in us
  localparam logic [4:0] PWRUP_CYC = 5'(PWRUP_US * CLK_MHZ); // hold-off cycles
  localparam logic [17:0] DATA_RST = 18'h00000;         // data register reset
endpackage

////////////////////////////////////////////////////////////////////////////////

module iop_interval_timer #(
  parameter int TICK_CYCLES = iop_pkg::TICK_CYCLES  // cycles between ticks
) (
  input  wire logic clk,    // system clock
  input  wire logic rst,    // async reset
  input  wire logic clr,    // bus power clear, synced
  input  wire logic run,    // clock enable, synced
  output var  logic tick    // one-cycle flag set pulse
);
  typedef struct packed {
    logic [iop_pkg::TICK_W-1:0] cnt;  // cycles since last tick
    logic                       tick; // registered tick
  } iop_tmr_s;

  iop_tmr_s q_r;   // state
  iop_tmr_s q_nxt; // next state

  // count while enabled, pulse at terminal count
  always_comb begin
    q_nxt      = q_r;
    q_nxt.tick = 1'b0;
    if (clr || !run) begin
      q_nxt.cnt = '0;
    end else if (q_r.cnt == iop_pkg::TICK_W'(TICK_CYCLES - 1)) begin
      q_nxt.cnt  = '0;
      q_nxt.tick = 1'b1;
    end else begin
      q_nxt.cnt = q_r.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign tick = q_r.tick;
endmodule // iop_interval_timer

`default_nettype wire

// *** iop_device.sv ***
/*
  i/o bus peripheral: select decode, 18-bit data register, contact switch
  readback, skip echo, status bit, interval flag with level 0 priority
  request and gated shared interrupt. all bus pins are asynchronous and
  pass two flip-flops. bus lines are carried active high here; the pad
  ring inverts the active-low wires.
*/
`default_nettype none

module iop_device #(
  parameter int TICK_CYCLES = iop_pkg::TICK_CYCLES  // interval in cycles
) (
  input  wire  logic        clk,                       // 20 MHz clock
  input  wire  logic        rst,                       // async reset
  input  wire  logic        bus_sync,                  // bus sync pulse
  input  wire  logic        bus_power_clear,           // bus power clear
  input  wire  logic        flag_test_pulse,           // test pulse
  input  wire  logic        device_to_cpu_pulse,       // read pulse
  input  wire  logic        cpu_to_device_pulse,       // write pulse
  input  wire  logic        status_readback,           // status read
  input  wire  logic        priority_level0_grant,     // level 0 grant
  input  wire  logic        priority_chain_enable_in,  // chain enable in
  input  wire  logic        priority_fitted,           // priority logic present
  input  wire  logic        clock_enable,              // interval clock enable
  input  wire  logic [7:0]  device_select_lines,       // device, subdevice
  input  wire  logic [17:0] bus_data_in,               // bus data, received
  input  wire  logic [17:0] contact_switches,          // switch states
  output var   logic [17:0] bus_data_out,              // bus data, driven
  output var   logic [17:0] bus_data_oe,               // per-line drive
  output var   logic        input_direction_request,   // read direction
  output var   logic        flag_test_echo,            // skip echo
  output var   logic        shared_interrupt_request,  // program interrupt
  output var   logic        priority_level0_request,   // level 0 request
  output var   logic        priority_chain_enable_out, // chain enable out
  output var   logic [5:0]  trap_addr_out,             // trap address
  output var   logic        trap_addr_oe,              // trap address drive
  output var   logic [17:0] data_register,             // loaded word
  output var   logic        interrupt_flag             // flag state
);
  typedef struct packed {
    logic [iop_pkg::PIN_W-1:0]  s1;        // sync stage 1
    logic [iop_pkg::PIN_W-1:0]  s2;        // sync stage 2
    logic [iop_pkg::CTL_W-1:0]  ctl_prev;  // previous controls
    logic [4:0]                 pwrup;     // internal clear counter
    logic [17:0]                data;      // data register
    logic                       flag;      // interrupt flag
    logic                       req;       // priority request
    logic                       served;    // granted, awaiting clear
    logic [17:0]                bus_out;   // bus data drive value
    logic [17:0]                bus_oe;    // bus data enables
    logic                       rd_req;    // input direction
    logic                       echo;      // skip echo
    logic                       pi_req;    // shared interrupt
    logic                       chain_out; // chain enable out
    logic                       trap_oe;   // trap address drive
    logic [5:0]                 trap_addr; // trap address drive value
  } iop_dev_s;

  iop_dev_s                  q_r;   // state
  iop_dev_s                  q_nxt; // next state
  logic                      tick;  // flag set pulse
  logic [iop_pkg::PIN_W-1:0] pins;  // raw pin vector

  assign pins = {contact_switches, bus_data_in, device_select_lines,
                 clock_enable, priority_fitted, priority_chain_enable_in,
                 priority_level0_grant, status_readback, cpu_to_device_pulse,
                 device_to_cpu_pulse, flag_test_pulse, bus_power_clear, bus_sync};

  //////////////////////////////////////////////////////////////////////////////

  // interval clock, cleared with power clear
  iop_interval_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk  (clk),
    .rst  (rst),
    .clr  (q_r.s2[iop_pkg::C_PCLR]),
    .run  (q_r.s2[iop_pkg::C_CLKEN]),
    .tick (tick)
  );

  //////////////////////////////////////////////////////////////////////////////

  // next state
  always_comb begin
    logic [iop_pkg::CTL_W-1:0] ctl;  // synced controls
    logic [iop_pkg::CTL_W-1:0] rise; // control rising edges
    logic [7:0]                sel;  // synced select code
    logic [17:0]               din;  // synced bus data
    logic [17:0]               sw;   // synced switches
    logic                      hit;  // transfer code selected
    logic                      clr;  // clear code selected
    logic                      rd;   // read active
    logic                      gate; // priority gate for shared interrupt
    ctl  = '0;
    rise = '0;
    sel  = '0;
    din  = '0;
    sw   = '0;
    hit  = 1'b0;
    clr  = 1'b0;
    rd   = 1'b0;
    gate = 1'b0;
    q_nxt          = q_r;
    q_nxt.s1       = pins;
    q_nxt.s2       = q_r.s1;
    ctl            = q_r.s2[iop_pkg::CTL_W-1:0];
    q_nxt.ctl_prev = ctl;
    rise           = ctl & ~q_r.ctl_prev;
    sel            = q_r.s2[iop_pkg::P_SEL +: iop_pkg::SEL_W];
    din            = q_r.s2[iop_pkg::P_DIN +: iop_pkg::DATA_W];
    sw             = q_r.s2[iop_pkg::P_SW +: iop_pkg::DATA_W];
    // full eight-bit decode, pulses are instruction bits 17-15
    hit = (sel == {iop_pkg::DEV_CODE, iop_pkg::SUB_XFER});
    clr = (sel == {iop_pkg::DEV_CODE, iop_pkg::SUB_CLR});
    // internal clear hold-off after reset
    if (q_r.pwrup != iop_pkg::PWRUP_CYC) begin
      q_nxt.pwrup = q_r.pwrup + 1'b1;
    end
    // write strobe
    if (hit && rise[iop_pkg::C_C2D]) begin
      q_nxt.data = din;
    end
    // clear command resets flag and request
    if (clr && rise[iop_pkg::C_D2C]) begin
      q_nxt.flag   = 1'b0;
      q_nxt.req    = 1'b0;
      q_nxt.served = 1'b0;
    end
    // a tick in the clear cycle still sets the flag
    if (tick && q_r.pwrup == iop_pkg::PWRUP_CYC) begin
      q_nxt.flag = 1'b1;
    end
    // request raised on sync only with chain in and priority logic fitted
    // uses the flag after this cycle's clear and tick, so a clear meeting sync raises nothing unless a tick comes too
    if (ctl[iop_pkg::C_FIT] && rise[iop_pkg::C_SYNC] && q_nxt.flag
        && ctl[iop_pkg::C_CHAIN] && !q_r.req && !q_r.served) begin
      q_nxt.req = 1'b1;
    end
    // grant ends: request drops, flag left alone
    if (!ctl[iop_pkg::C_GRANT] && q_r.ctl_prev[iop_pkg::C_GRANT] && q_r.req) begin
      q_nxt.req    = 1'b0;
      q_nxt.served = 1'b1;
    end
    // chain out dropped while requesting
    q_nxt.chain_out = ctl[iop_pkg::C_CHAIN] & ~q_nxt.req;
    // trap address during our grant
    q_nxt.trap_oe   = ctl[iop_pkg::C_GRANT] & q_nxt.req;
    q_nxt.trap_addr = q_nxt.trap_oe ? iop_pkg::TRAP_ADDR : 6'h00;
    // shared interrupt gated with priority request, or open gate if absent
    gate         = ~ctl[iop_pkg::C_FIT] | q_nxt.req | q_nxt.served;
    q_nxt.pi_req = q_nxt.flag & gate;
    // skip echo while test pulse, selected, flag up
    q_nxt.echo = hit & ctl[iop_pkg::C_TEST] & q_r.flag;
    // read: switches onto bus plus direction request
    rd            = hit & ctl[iop_pkg::C_D2C];
    q_nxt.rd_req  = rd;
    q_nxt.bus_out = rd ? sw : '0;
    q_nxt.bus_oe  = rd ? {iop_pkg::DATA_W{1'b1}} : '0;
    // status read drives the flag on its own line, selected or not
    if (ctl[iop_pkg::C_STAT]) begin
      q_nxt.bus_out[iop_pkg::STATUS_BIT] = q_nxt.bus_out[iop_pkg::STATUS_BIT] | q_r.flag;
      q_nxt.bus_oe[iop_pkg::STATUS_BIT]  = 1'b1;
    end
    // bus power clear resets the flags and the data register
    if (ctl[iop_pkg::C_PCLR]) begin
      q_nxt.data   = iop_pkg::DATA_RST;
      q_nxt.flag   = 1'b0;
      q_nxt.req    = 1'b0;
      q_nxt.served = 1'b0;
      q_nxt.pi_req = 1'b0;
      q_nxt.echo   = 1'b0;
      q_nxt.trap_oe   = 1'b0;  // no trap drive through a clear
      q_nxt.trap_addr = 6'h00;
      q_nxt.chain_out = ctl[iop_pkg::C_CHAIN];
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // outputs, all from flip-flops
  assign bus_data_out              = q_r.bus_out;
  assign bus_data_oe               = q_r.bus_oe;
  assign input_direction_request   = q_r.rd_req;
  assign flag_test_echo            = q_r.echo;
  assign shared_interrupt_request  = q_r.pi_req;
  assign priority_level0_request   = q_r.req;
  assign priority_chain_enable_out = q_r.chain_out;
  assign trap_addr_out             = q_r.trap_addr;
  assign trap_addr_oe              = q_r.trap_oe;
  assign data_register             = q_r.data;
  assign interrupt_flag            = q_r.flag;
endmodule // iop_device

`default_nettype wire

// *** iop_device_monitor.sv ***
/*
  checker for the i/o bus peripheral: timing relations seen at its pins.
  assumes the ports of iop_device and a 3-edge latency from pin to output.
*/
`default_nettype none

module iop_device_monitor (
  input wire logic        clk,                       // clock
  input wire logic        rst,                       // async reset
  input wire logic        bus_power_clear,           // power clear
  input wire logic        flag_test_pulse,           // test pulse
  input wire logic        status_readback,           // status read
  input wire logic        device_to_cpu_pulse,       // read pulse
  input wire logic        cpu_to_device_pulse,       // write pulse
  input wire logic        priority_fitted,           // strap
  input wire logic [7:0]  device_select_lines,       // select code
  input wire logic [17:0] contact_switches,          // switches
  input wire logic [17:0] bus_data_out,              // drive value
  input wire logic [17:0] bus_data_oe,               // drive enables
  input wire logic [17:0] data_register,             // loaded word
  input wire logic        input_direction_request,   // direction
  input wire logic        flag_test_echo,            // echo
  input wire logic        shared_interrupt_request,  // shared interrupt
  input wire logic        priority_level0_request,   // level 0 request
  input wire logic        priority_chain_enable_out, // chain out
  input wire logic        trap_addr_oe,              // trap drive
  input wire logic [5:0]  trap_addr_out,             // trap address
  input wire logic        interrupt_flag             // flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  a_write_needs_sel: assert property ($changed(data_register) |->
    ($past(cpu_to_device_pulse, 3) && $past(device_select_lines, 3) == 8'hA8)
    || $past(bus_power_clear, 3) || $past(bus_power_clear, 4)) else $error("data register changed unasked");
  a_flag_clear_cause: assert property ($fell(interrupt_flag) |->
    ($past(device_to_cpu_pulse, 3) && $past(device_select_lines, 3) == 8'hA9)
    || $past(bus_power_clear, 3) || $past(bus_power_clear, 4)) else $error("flag fell without clear");
  a_read_drives_bus: assert property ($past(device_to_cpu_pulse, 3) && $past(device_select_lines, 3) == 8'hA8 |->
    bus_data_oe == 18'h3FFFF && input_direction_request && bus_data_out == $past(contact_switches, 3))
    else $error("read did not drive switches");
  a_read_needs_sel: assert property (input_direction_request |->
    $past(device_to_cpu_pulse, 3) && $past(device_select_lines, 3) == 8'hA8) else $error("stray direction");
  a_data_lines_quiet: assert property (|(bus_data_oe & 18'h3FFDF) |-> input_direction_request)
    else $error("data lines driven outside a read");
  a_echo_needs_sel: assert property (flag_test_echo |->
    $past(flag_test_pulse, 3) && $past(device_select_lines, 3) == 8'hA8) else $error("stray echo");
  a_request_with_int: assert property ($rose(priority_level0_request) |->
    shared_interrupt_request && interrupt_flag) else $error("request without interrupt");
  a_chain_blocked: assert property (priority_level0_request |-> !priority_chain_enable_out)
    else $error("chain left open while requesting");
  a_trap_addr_value: assert property (trap_addr_oe |->
    trap_addr_out == iop_pkg::TRAP_ADDR && priority_level0_request) else $error("wrong trap address");
  a_int_gate_fitted: assert property ($rose(shared_interrupt_request) && $past(priority_fitted, 3) |->
    priority_level0_request) else $error("interrupt ahead of priority request");
  a_status_bit_drive: assert property ($past(status_readback, 3) |-> bus_data_oe[iop_pkg::STATUS_BIT])
    else $error("status line not driven");
  c_request: cover property ($rose(priority_level0_request));
  c_trap: cover property (trap_addr_oe);
  c_echo: cover property (flag_test_echo);
  c_read: cover property (input_direction_request);
endmodule // iop_device_monitor

bind iop_device iop_device_monitor i_iop_device_monitor (.*);

`default_nettype wire

// *** iop_cpu_model.sv ***
/*
  cpu side of the i/o bus: 250 ns sync pulse every 1 us and the level 0 grant.
  assumes the device drops its request when the grant ends.
*/
`default_nettype none

module iop_cpu_model (
  input  wire logic clk,                     // system clock
  input  wire logic rst,                     // async reset
  input  wire logic priority_level0_request, // device request
  input  wire logic grant_enable,            // priority system enabled
  output var  logic bus_sync,                // sync pulse
  output var  logic priority_level0_grant    // level 0 grant
);
  timeunit 1ns;
  timeprecision 1ns;
  int phase; // place in the 1 us frame
  int hold;  // grant countdown
  ////////////////////////////////////////////////////////////
  // sync and grant, launched on the falling edge
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      phase = 0;
      hold = 0;
      bus_sync <= 1'h0;
      priority_level0_grant <= 1'h0;
    end else begin
      phase = (phase + 1) % 20;
      bus_sync <= (phase < 5);
      // grant for four counts, then four idle counts so a request still falling is not granted again
      if (hold > 0) hold = hold - 1;
      else if (grant_enable && priority_level0_request) hold = 12;
      priority_level0_grant <= (hold > 4 && hold < 9);
    end
  end
endmodule // iop_cpu_model

`default_nettype wire

// *** test_iop_device.sv ***
/*
  self-checking bench for iop_device: transfer table, then power clear,
  priority chain, skip, status, clear and the no-priority path.
  assumes iop_cpu_model for sync and grant, 20 MHz clock.
*/
`default_nettype none

module test_iop_device;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [7:0]  sel;     // select code
    logic [3:0]  op;      // status, test, read, write
    logic [17:0] val;     // data and switches
    logic [17:0] exp_reg; // register after
    logic [17:0] exp_oe;  // drive expected
    logic        exp_dir; // direction expected
  } iop_tb_row_s;
  logic clk = 1'h0, rst = 1'h1, bus_sync, bus_power_clear = 1'h0, flag_test_pulse = 1'h0;
  logic device_to_cpu_pulse = 1'h0, cpu_to_device_pulse = 1'h0, status_readback = 1'h0;
  logic priority_level0_grant, priority_chain_enable_in = 1'h0, priority_fitted = 1'h1;
  logic clock_enable = 1'h0, grant_enable = 1'h0;
  logic [7:0] device_select_lines = 8'h00;
  logic [17:0] bus_data_in = 18'h00000, contact_switches = 18'h00000;
  logic [17:0] bus_data_out, bus_data_oe, data_register;
  logic input_direction_request, flag_test_echo, shared_interrupt_request, priority_level0_request;
  logic priority_chain_enable_out, trap_addr_oe, interrupt_flag;
  logic [5:0] trap_addr_out;
  int mismatches = 0, comparisons = 0;
  iop_tb_row_s rows [7] = '{
    '{8'hA8, 4'h1, 18'h00000, 18'h00000, 18'h00000, 1'h0},  // write zero
    '{8'hA8, 4'h1, 18'h2AAAA, 18'h2AAAA, 18'h00000, 1'h0},  // write
    '{8'hA4, 4'h1, 18'h15555, 18'h2AAAA, 18'h00000, 1'h0},  // other device
    '{8'hAA, 4'h1, 18'h15555, 18'h2AAAA, 18'h00000, 1'h0},  // other subdevice
    '{8'hA8, 4'h2, 18'h3F0F0, 18'h2AAAA, 18'h3FFFF, 1'h1},  // read
    '{8'hAB, 4'h2, 18'h3F0F0, 18'h2AAAA, 18'h00000, 1'h0},  // read, other subdevice
    '{8'hA8, 4'h1, 18'h3FFFF, 18'h3FFFF, 18'h00000, 1'h0}}; // write all ones
  iop_device #(.TICK_CYCLES(16)) i_iop_device (.*);
  iop_cpu_model i_iop_cpu_model (.*);
  ////////////////////////////////////////////////////////////
  always #25 clk = ~clk; // 20 MHz
  // compare and count
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // counts and verdict
  task automatic tally_and_finish();
    $display("compared %0d, mismatched %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one bus cycle; pulses stay up so the caller can look
  task automatic xfer(input logic [7:0] sel, input logic [3:0] op, input logic [17:0] val);
    {status_readback, flag_test_pulse, device_to_cpu_pulse, cpu_to_device_pulse} = 4'h0;
    repeat (4) @(negedge clk);
    device_select_lines = sel;
    bus_data_in = val;
    contact_switches = val;
    repeat (2) @(negedge clk);
    {status_readback, flag_test_pulse, device_to_cpu_pulse, cpu_to_device_pulse} = op;
    repeat (4) @(negedge clk);
  endtask
  // bounded wait on flag, request, trap drive or interrupt
  function automatic logic pick(input int which);
    case (which)
      0: return interrupt_flag;
      1: return priority_level0_request;
      2: return trap_addr_oe;
      default: return shared_interrupt_request;
    endcase
  endfunction
  task automatic await(input int which, input logic want);
    for (int i = 0; i < 400 && pick(which) !== want; i++) @(negedge clk);
    if (pick(which) !== want) begin
      mismatches++;
      $display("unexpected at %0t: wait %0d ran out", $time, which);
      tally_and_finish();
    end
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
    chk(18'({shared_interrupt_request, priority_level0_request, trap_addr_oe, interrupt_flag}), 18'h00000);
    foreach (rows[k]) begin
      xfer(rows[k].sel, rows[k].op, rows[k].val);
      chk(data_register, rows[k].exp_reg);
      chk(bus_data_oe, rows[k].exp_oe);
      chk(bus_data_out & bus_data_oe, rows[k].exp_oe & rows[k].val);
      chk(18'(input_direction_request), 18'(rows[k].exp_dir));
    end
    $display("test table done");
    bus_power_clear = 1'h1;
    repeat (5) @(negedge clk);
    bus_power_clear = 1'h0;
    repeat (4) @(negedge clk);
    chk(data_register, 18'h00000);
    chk(18'(interrupt_flag), 18'h00000);
    $display("test power clear done");
    grant_enable = 1'h1;
    clock_enable = 1'h1;
    await(0, 1'h1);
    clock_enable = 1'h0;
    repeat (45) @(negedge clk);
    chk(18'({priority_level0_request, shared_interrupt_request}), 18'h00000);
    priority_chain_enable_in = 1'h1;
    await(1, 1'h1);
    chk(18'({shared_interrupt_request, priority_chain_enable_out}), 18'h00002);
    await(2, 1'h1);
    chk(18'(trap_addr_out), 18'h00024);
    await(1, 1'h0);
    chk(18'({shared_interrupt_request, interrupt_flag}), 18'h00003);
    xfer(8'hA8, 4'h4, 18'h00000);
    chk(18'(flag_test_echo), 18'h00001);
    xfer(8'h00, 4'h8, 18'h00000);
    chk(18'({bus_data_oe[5], bus_data_out[5]}), 18'h00003);
    xfer(8'hA9, 4'h2, 18'h00000);
    chk(18'({interrupt_flag, shared_interrupt_request, priority_level0_request}), 18'h00000);
    xfer(8'hA8, 4'h4, 18'h00000);
    chk(18'(flag_test_echo), 18'h00000);
    xfer(8'h00, 4'h0, 18'h00000);
    $display("test priority path done");
    priority_fitted = 1'h0;
    grant_enable = 1'h0;
    repeat (4) @(negedge clk);
    clock_enable = 1'h1;
    await(3, 1'h1);
    clock_enable = 1'h0;
    chk(18'({interrupt_flag, shared_interrupt_request, priority_level0_request}), 18'h00006);
    xfer(8'hA9, 4'h2, 18'h00000);
    chk(18'({interrupt_flag, shared_interrupt_request}), 18'h00000);
    $display("test no priority done");
    // mid-run reset with the interval clock running: early tick must not set the flag
    xfer(8'hA8, 4'h1, 18'h15555);
    xfer(8'h00, 4'h0, 18'h00000);
    chk(data_register, 18'h15555);
    clock_enable = 1'h1;
    rst = 1'h1;
    repeat (4) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
    chk(data_register, 18'h00000);
    chk(18'({interrupt_flag, shared_interrupt_request, flag_test_echo, input_direction_request}), 18'h00000);
    repeat (24) @(negedge clk);
    chk(18'(interrupt_flag), 18'h00000);
    await(0, 1'h1);
    clock_enable = 1'h0;
    $display("test reset done");
    tally_and_finish();
  end
endmodule // test_iop_device

`default_nettype wire
